// ==== design/aofg_pkg.sv ====
// Overview of operation
// - bit 15 picks byte-wise or word-wise order
// - bit 8: upper/lower or odd/even lanes, only while bit 15 is set (else held 0)
// - per-channel bits alternate whole samples on lanes, only while bit 15 is set (else held 0)
// - filter block enable at bit one
// - channel 2 gain in bits 11:8
// - channel 1 gain in bits 3:0
// - channel 3 gain in bits 11:8
// - channel 4 gain in bits 3:0
// - all registers reset zero, read/write
package aofg_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0]  AOFG_IDX_FORMAT   = 8'h28;
    localparam logic [7:0]  AOFG_IDX_FILTER   = 8'h29;
    localparam logic [7:0]  AOFG_IDX_GAIN12   = 8'h2A;
    localparam logic [7:0]  AOFG_IDX_GAIN34   = 8'h2B;
    localparam int          AOFG_NUM_REGS     = 4;
    localparam logic [15:0] AOFG_RESET_VALUE  = 16'h0000;
    // ****************************************
    // field positions
    // ****************************************
    localparam int AOFG_POS_LANE_ORDER   = 15;
    localparam int AOFG_POS_INTERLEAVE   = 8;
    localparam int AOFG_POS_ALT_LSB      = 0;
    localparam int AOFG_ALT_WIDTH        = 8;
    localparam int AOFG_POS_FILTER_EN    = 1;
    localparam int AOFG_POS_GAIN_HI      = 8;
    localparam int AOFG_POS_GAIN_LO      = 0;
    localparam int AOFG_GAIN_WIDTH       = 4;

    typedef enum logic [1:0] {
        AOFG_SLOT_FORMAT,
        AOFG_SLOT_FILTER,
        AOFG_SLOT_GAIN12,
        AOFG_SLOT_GAIN34
    } aofg_slot_type;
endpackage : aofg_pkg

// ==== design/aofg_reg_bank.sv ====
`timescale 1ns/1ps
module aofg_reg_bank
    import aofg_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    aofg_reg_if.bank    rif
);
    // ****************************************
    // storage, one word per slot
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < AOFG_NUM_REGS; g++) begin : g_reg
            // don't-care bits kept so software reads back what it wrote
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    rif.regs[g] <= AOFG_RESET_VALUE;
                end else if (rif.wr && rif.slot == 2'(g)) begin
                    if (rif.wsel[0]) begin
                        rif.regs[g][7:0] <= rif.wdata[7:0];
                    end
                    if (rif.wsel[1]) begin
                        rif.regs[g][15:8] <= rif.wdata[15:8];
                    end
                end
            end
        end
    endgenerate
endmodule : aofg_reg_bank

// ==== design/aofg_reg_if.sv ====
`timescale 1ns/1ps
interface aofg_reg_if;
    logic        wr;
    logic [1:0]  slot;
    logic [15:0] wdata;
    logic [1:0]  wsel;
    logic [15:0] regs [4];
    modport bank (input wr, input slot, input wdata, input wsel, output regs);
    modport ctrl (output wr, output slot, output wdata, output wsel, input regs);
endinterface : aofg_reg_if

// ==== design/aofg_top.sv ====
`timescale 1ns/1ps
module aofg_top
    import aofg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        sample_strobe_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic             lane_order_select_o,
    output logic             interleave_odd_even_o,
    output logic      [7:0]  per_channel_sample_alternate_o,
    output logic             filter_block_enable_o,
    output logic      [3:0]  amp_factor_first_o,
    output logic      [3:0]  amp_factor_second_o,
    output logic      [3:0]  amp_factor_third_o,
    output logic      [3:0]  amp_factor_fourth_o
);
    aofg_reg_if rif ();

    aofg_reg_bank u_bank (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .rif   (rif)
    );

    // ****************************************
    // wishbone decode
    // ****************************************
    logic        req;
    logic        hit;
    logic [1:0]  next_slot;
    logic [29:0] word_idx;

    assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign word_idx = wb_adr_i[31:2];
    always_comb begin
        hit       = 1'b1;
        next_slot = 2'd0;
        unique case (word_idx)
            30'(AOFG_IDX_FORMAT): next_slot = 2'(AOFG_SLOT_FORMAT);
            30'(AOFG_IDX_FILTER): next_slot = 2'(AOFG_SLOT_FILTER);
            30'(AOFG_IDX_GAIN12): next_slot = 2'(AOFG_SLOT_GAIN12);
            30'(AOFG_IDX_GAIN34): next_slot = 2'(AOFG_SLOT_GAIN34);
            default:              hit       = 1'b0;
        endcase
    end

    // write lands on the ack edge so master and slave agree on the moment
    // ack only rises for a mapped word, and the master holds the address until then
    assign rif.wr    = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
    assign rif.slot  = next_slot;
    assign rif.wdata = wb_dat_i[15:0];
    assign rif.wsel  = wb_sel_i[1:0];

    // single-cycle answer; ack drops the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit;
        end
    end

    // upper half reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && hit && !wb_we_i) begin
            wb_dat_o <= {16'h0000, rif.regs[next_slot]};
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // ****************************************
    // apply settings at sample boundary
    // ****************************************
    // register copies move only on a strobe, so a sample never sees a half-written format
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lane_order_select_o            <= 1'b0;
            interleave_odd_even_o          <= 1'b0;
            per_channel_sample_alternate_o <= 8'h00;
        end else if (sample_strobe_i) begin
            lane_order_select_o <= rif.regs[AOFG_SLOT_FORMAT][AOFG_POS_LANE_ORDER];
            // lower format bits only act once lane order is set by software
            if (rif.regs[AOFG_SLOT_FORMAT][AOFG_POS_LANE_ORDER]) begin
                interleave_odd_even_o <=
                    rif.regs[AOFG_SLOT_FORMAT][AOFG_POS_INTERLEAVE];
                per_channel_sample_alternate_o <=
                    rif.regs[AOFG_SLOT_FORMAT][AOFG_POS_ALT_LSB +: AOFG_ALT_WIDTH];
            end else begin
                interleave_odd_even_o          <= 1'b0;
                per_channel_sample_alternate_o <= 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filter_block_enable_o <= 1'b0;
        end else if (sample_strobe_i) begin
            filter_block_enable_o <= rif.regs[AOFG_SLOT_FILTER][AOFG_POS_FILTER_EN];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amp_factor_first_o  <= 4'h0;
            amp_factor_second_o <= 4'h0;
            amp_factor_third_o  <= 4'h0;
            amp_factor_fourth_o <= 4'h0;
        end else if (sample_strobe_i) begin
            amp_factor_second_o <=
                rif.regs[AOFG_SLOT_GAIN12][AOFG_POS_GAIN_HI +: AOFG_GAIN_WIDTH];
            amp_factor_first_o  <=
                rif.regs[AOFG_SLOT_GAIN12][AOFG_POS_GAIN_LO +: AOFG_GAIN_WIDTH];
            amp_factor_third_o  <=
                rif.regs[AOFG_SLOT_GAIN34][AOFG_POS_GAIN_HI +: AOFG_GAIN_WIDTH];
            amp_factor_fourth_o <=
                rif.regs[AOFG_SLOT_GAIN34][AOFG_POS_GAIN_LO +: AOFG_GAIN_WIDTH];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    ack_follows_req_a: assert property (req && hit |=> wb_ack_o)
        else $error("mapped access not acked");
    err_on_unmapped_a: assert property (req && !hit |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    lane_order_follow_a: assert property (sample_strobe_i |=>
        lane_order_select_o == $past(rif.regs[0][15]))
        else $error("lane order not applied");
    format_gated_a: assert property (!lane_order_select_o |->
        !interleave_odd_even_o && per_channel_sample_alternate_o == 8'h00)
        else $error("format active without lane order");
    interleave_follow_a: assert property (sample_strobe_i && rif.regs[0][15] |=>
        interleave_odd_even_o == $past(rif.regs[0][8]))
        else $error("interleave not applied");
    alternate_follow_a: assert property (sample_strobe_i && rif.regs[0][15] |=>
        per_channel_sample_alternate_o == $past(rif.regs[0][7:0]))
        else $error("alternate bits not applied");
    filter_follow_a: assert property (sample_strobe_i |=>
        filter_block_enable_o == $past(rif.regs[1][1]))
        else $error("filter enable not applied");
    gain_second_a: assert property (sample_strobe_i |=>
        amp_factor_second_o == $past(rif.regs[2][11:8]))
        else $error("channel 2 gain wrong");
    gain_first_a: assert property (sample_strobe_i |=>
        amp_factor_first_o == $past(rif.regs[2][3:0]))
        else $error("channel 1 gain wrong");
    gain_third_a: assert property (sample_strobe_i |=>
        amp_factor_third_o == $past(rif.regs[3][11:8]))
        else $error("channel 3 gain wrong");
    gain_fourth_a: assert property (sample_strobe_i |=>
        amp_factor_fourth_o == $past(rif.regs[3][3:0]))
        else $error("channel 4 gain wrong");
    hold_no_strobe_a: assert property (!sample_strobe_i |=>
        $stable(amp_factor_first_o) && $stable(lane_order_select_o))
        else $error("setting changed between samples");
    write_stored_a: assert property (rif.wr && rif.wsel == 2'b11 |=>
        rif.regs[$past(rif.slot)] == $past(rif.wdata))
        else $error("write not stored");

    write_cov_c: cover property (wb_ack_o && wb_we_i);
    read_cov_c: cover property (wb_ack_o && !wb_we_i && wb_dat_o != 32'h0);
    err_cov_c: cover property (wb_err_o);
    fmt_cov_c: cover property (lane_order_select_o && interleave_odd_even_o);
endmodule : aofg_top

// ==== test/aofg_tb_top.sv ====
`timescale 1ns/1ps
module aofg_tb_top;
    import aofg_pkg::*;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic        clk_i = 1'b0;
    logic        rst_i;
    logic        sample_strobe_i;
    logic [31:0] wb_adr_i;
    logic [31:0] wb_dat_i;
    logic [3:0]  wb_sel_i;
    logic        wb_we_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        wb_err_o;
    logic        lane_o;
    logic        inter_o;
    logic [7:0]  alt_o;
    logic        filt_o;
    logic [3:0]  amp1_o;
    logic [3:0]  amp2_o;
    logic [3:0]  amp3_o;
    logic [3:0]  amp4_o;
    logic [15:0] mem [4];
    logic [26:0] applied;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          seed = 32'hd0f20c9e;
    int          cycles = 0;

    always #10 clk_i = ~clk_i;

    aofg_top dut (.clk_i(clk_i), .rst_i(rst_i), .sample_strobe_i(sample_strobe_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .lane_order_select_o(lane_o), .interleave_odd_even_o(inter_o),
        .per_channel_sample_alternate_o(alt_o), .filter_block_enable_o(filt_o),
        .amp_factor_first_o(amp1_o), .amp_factor_second_o(amp2_o),
        .amp_factor_third_o(amp3_o), .amp_factor_fourth_o(amp4_o));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [26:0] exp_out(input logic [15:0] f, input logic [15:0] fl,
                                            input logic [15:0] g12, input logic [15:0] g34);
        // low format bits only count once the order select is set
        return {f[15], f[15] & f[8], f[15] ? f[7:0] : 8'h00, fl[1],
                g12[3:0], g12[11:8], g34[11:8], g34[3:0]};
    endfunction : exp_out

    function automatic logic [31:0] adr(input int i);
        return {22'h0, AOFG_IDX_FORMAT + 8'(i), 2'b00};
    endfunction : adr

    task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic er);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic readback(input string msg);
        logic [31:0] rd;
        logic        er;
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, adr(i), 32'h0, 4'hF, rd, er);
            chk({er, rd}, {17'h0, mem[i]}, msg);
        end
    endtask : readback

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // a hang shows up as a mismatch, never as a silent stall
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] d;
        logic [31:0] rd;
        logic [3:0]  s;
        logic        er;
        rst_i = 1'b1;
        sample_strobe_i = 1'b0;
        {wb_adr_i, wb_dat_i, wb_sel_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
        for (int i = 0; i < 4; i++) mem[i] = 16'h0000;
        applied = '0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({lane_o, inter_o, alt_o, filt_o, amp1_o, amp2_o, amp3_o, amp4_o}, 33'h0, "reset out");
        readback("reset value");
        $display("test reset done");
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 4; i++) begin
                d = $random(seed);
                s = 4'($random(seed));
                if (k == 0) {d, s} = {32'hFFFF_FFFF, 4'hF};
                if (k == 1) {d, s} = {32'h0000_7FFF, 4'hF};
                wb(1'b1, adr(i), d, s, rd, er);
                chk({32'h0, er}, 33'h0, "write err");
                if (s[0]) mem[i][7:0] = d[7:0];
                if (s[1]) mem[i][15:8] = d[15:8];
            end
            chk({lane_o, inter_o, alt_o, filt_o, amp1_o, amp2_o, amp3_o, amp4_o}, applied, "early");
            sample_strobe_i <= 1'b1;
            @(posedge clk_i);
            sample_strobe_i <= 1'b0;
            @(posedge clk_i);
            applied = exp_out(mem[0], mem[1], mem[2], mem[3]);
            chk({lane_o, inter_o, alt_o, filt_o, amp1_o, amp2_o, amp3_o, amp4_o}, applied, "fields");
            readback("readback");
        end
        $display("test random fields done");
        foreach (d[j]) begin
            if (j < 3) begin
                wb(1'b1, (j == 0) ? 32'h28 : ((j == 1) ? 32'hB0 : 32'h9C), '1, 4'hF, rd, er);
                chk({er, rd}, {1'b1, 32'h0}, "unmapped");
            end
        end
        readback("after unmapped");
        $display("test unmapped done");
        test_done();
    end
endmodule : aofg_tb_top
